// file: verilog/bpeu_exec.sv
// Fetch, decode and execute for pointer increment, relative branches,
// indirect jump, long call and long jump.
// Assumes program memory answers code_rd with code_valid, and the bit
// space answers bit_rd with bit_valid, both on ref_clk.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Pointer increment adds one to the 16-bit data pointer, wrapping, no flags.
// [RULE2] Three-byte bit branches target next address plus signed third byte.
// [RULE3] Two-byte branches advance by two, then add signed second byte if true.
// [RULE4] Branch-if-bit-set jumps on a one and leaves the bit alone.
// [RULE5] Set-and-clear branch clears and jumps on a one; no write on zero.
// [RULE6] Set-and-clear reads port bits from the output latch, not the pin.
// [RULE7] Branch-if-bit-clear jumps on a zero and leaves the bit alone.
// [RULE8] Carry branch jumps only when carry is one.
// [RULE9] No-carry branch jumps only when carry is zero, carry untouched.
// [RULE10] Nonzero-accumulator branch jumps when any bit is one.
// [RULE11] Zero-accumulator branch jumps when all eight bits are zero.
// [RULE12] Indirect jump loads accumulator plus data pointer, wrapping, both unchanged.
// [RULE13] Long call adds three, pushes low then high, pre-incrementing stack pointer.
// [RULE14] Long call then loads high byte from byte two, low from byte three.
// [RULE15] Long jump loads the address from bytes two and three, no flags.
// [RULE16] Conditional branches never touch carry or any status flag.
// [RULE17] Relative targets wrap modulo 65536 with no flag or exception.
module bpeu_exec
  import bpeu_pkg::*;
#(
  parameter int unsigned SP_W = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  output logic      [bpeu_pkg::PC_W-1:0] code_addr,
  output logic                      code_rd,
  input  wire logic [7:0]           code_data,
  input  wire logic                 code_valid,
  input  wire logic [7:0]           acc,
  input  wire logic                 carry_flag,
  output logic      [7:0]           bit_addr,
  output logic                      bit_rd,
  output logic                      bit_from_latch,
  input  wire logic                 bit_value,
  input  wire logic                 bit_valid,
  output logic                      bit_wr,
  output logic                      bit_wdata,
  input  wire logic                 pointer_load,
  input  wire logic [15:0]          pointer_load_value,
  input  wire logic                 sp_load,
  input  wire logic [SP_W-1:0]      sp_load_value,
  input  wire logic [SP_W-1:0]      stack_rd_addr,
  output logic      [7:0]           stack_rd_data,
  output logic      [bpeu_pkg::PC_W-1:0] program_counter,
  output logic      [15:0]          data_pointer,
  output logic      [7:0]           pointer_low_byte,
  output logic      [7:0]           pointer_high_byte,
  output logic      [SP_W-1:0]      stack_pointer,
  output logic                      instr_done,
  output logic                      unsupported_op
);
  import bpeu_pkg::*;

  function automatic logic [1:0] op_len(input logic [7:0] op);
    unique case (op)
      OP_BIT_SET, OP_BIT_SETCL, OP_BIT_CLR,
      OP_LONG_CALL, OP_LONG_JUMP:             op_len = LEN_THREE;
      OP_CARRY, OP_NO_CARRY,
      OP_ACC_ZERO, OP_ACC_NZERO:              op_len = LEN_TWO;
      default:                                op_len = LEN_ONE;
    endcase
  endfunction

  function automatic logic is_bit_op(input logic [7:0] op);
    is_bit_op = (op == OP_BIT_SET) || (op == OP_BIT_SETCL) || (op == OP_BIT_CLR);
  endfunction

  bpeu_state_t      state, next_state;
  logic [PC_W-1:0]  fetch_addr, next_fetch_addr;
  logic [1:0]       byte_idx, next_byte_idx;
  logic [7:0]       opcode, next_opcode;
  logic [7:0]       byte2, next_byte2;
  logic [7:0]       byte3, next_byte3;
  logic             bit_seen, next_bit_seen;
  logic [PC_W-1:0]  next_code_addr, next_program_counter;
  logic             next_code_rd, next_bit_rd, next_bit_from_latch;
  logic [7:0]       next_bit_addr;
  logic             next_bit_wr, next_instr_done, next_unsupported_op;
  logic [15:0]      next_data_pointer;
  logic [SP_W-1:0]  next_stack_pointer;
  logic [PC_W-1:0]  seq_addr, target3, target2;
  logic             ram_we;
  logic [SP_W-1:0]  ram_waddr;
  logic [7:0]       ram_wdata;
  logic [7:0]       next_byte_cur;
  logic             taken;

  assign seq_addr = program_counter + {{(PC_W-2){1'b0}}, op_len(opcode)};

  // [RULE2] [RULE17] Three-byte target
  bpeu_rel_add #(.W(PC_W)) u_add3 (
    .base   (seq_addr),
    .disp   (byte3),
    .target (target3)
  );

  // [RULE3] [RULE17] Two-byte target
  bpeu_rel_add #(.W(PC_W)) u_add2 (
    .base   (seq_addr),
    .disp   (byte2),
    .target (target2)
  );

  bpeu_stack_ram #(.AW(SP_W), .DW(8)) u_stack (
    .ref_clk (ref_clk),
    .wr_en   (ram_we),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (stack_rd_addr),
    .rd_data (stack_rd_data)
  );

  always_comb begin
    unique case (opcode)
      // [RULE4] Branch on one
      OP_BIT_SET:   taken = bit_seen;
      // [RULE5] Branch and clear on one
      OP_BIT_SETCL: taken = bit_seen;
      // [RULE7] Branch on zero
      OP_BIT_CLR:   taken = !bit_seen;
      // [RULE8] Carry set
      OP_CARRY:     taken = carry_flag;
      // [RULE9] Carry clear
      OP_NO_CARRY:  taken = !carry_flag;
      // [RULE11] All bits zero
      OP_ACC_ZERO:  taken = (acc == ZERO_BYTE);
      // [RULE10] Any bit one
      OP_ACC_NZERO: taken = (acc != ZERO_BYTE);
      default:      taken = 1'b0;
    endcase
  end

  always_comb begin
    next_state           = state;
    next_fetch_addr      = fetch_addr;
    next_byte_idx        = byte_idx;
    next_opcode          = opcode;
    next_byte2           = byte2;
    next_byte3           = byte3;
    next_bit_seen        = bit_seen;
    next_code_addr       = code_addr;
    next_code_rd         = 1'b0;
    next_bit_rd          = 1'b0;
    next_bit_addr        = bit_addr;
    next_bit_from_latch  = bit_from_latch;
    next_bit_wr          = 1'b0;
    next_program_counter = program_counter;
    next_data_pointer    = data_pointer;
    next_stack_pointer   = stack_pointer;
    next_instr_done      = 1'b0;
    next_unsupported_op  = 1'b0;
    ram_we               = 1'b0;
    ram_waddr            = stack_pointer;
    ram_wdata            = ZERO_BYTE;
    next_byte_cur        = (byte_idx == 2'h0) ? code_data : opcode;
    unique case (state)
      ST_REQ: begin
        next_code_rd   = 1'b1;
        next_code_addr = fetch_addr;
        next_state     = ST_WAIT;
      end
      ST_WAIT: begin
        if (code_valid) begin
          unique case (byte_idx)
            2'h0:    next_opcode = code_data;
            2'h1:    next_byte2  = code_data;
            default: next_byte3  = code_data;
          endcase
          next_fetch_addr = fetch_addr + ONE_WORD;
          if (byte_idx + 2'h1 < op_len(next_byte_cur)) begin
            next_byte_idx = byte_idx + 2'h1;
            next_state    = ST_REQ;
          end else begin
            next_byte_idx = 2'h0;
            next_state    = is_bit_op(next_byte_cur) ? ST_BIT_REQ : ST_EXEC;
          end
        end
      end
      ST_BIT_REQ: begin
        next_bit_rd         = 1'b1;
        next_bit_addr       = byte2;
        // [RULE6] Latch source for clear form
        next_bit_from_latch = (opcode == OP_BIT_SETCL);
        next_state          = ST_BIT_WAIT;
      end
      ST_BIT_WAIT: begin
        if (bit_valid) begin
          next_bit_seen = bit_value;
          next_state    = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state           = ST_REQ;
        next_instr_done      = 1'b1;
        next_program_counter = seq_addr;
        next_fetch_addr      = seq_addr;
        unique case (opcode)
          // [RULE1] Sixteen-bit increment
          OP_PTR_INC: next_data_pointer = data_pointer + ONE_WORD;
          // [RULE2] [RULE4] [RULE7] Bit branch
          OP_BIT_SET, OP_BIT_CLR: begin
            if (taken) begin
              next_program_counter = target3;
              next_fetch_addr      = target3;
            end
          end
          // [RULE5] Clear only when set
          OP_BIT_SETCL: begin
            if (taken) begin
              next_bit_wr          = 1'b1;
              next_program_counter = target3;
              next_fetch_addr      = target3;
            end
          end
          // [RULE3] [RULE16] Flagless short branch
          OP_CARRY, OP_NO_CARRY, OP_ACC_ZERO, OP_ACC_NZERO: begin
            if (taken) begin
              next_program_counter = target2;
              next_fetch_addr      = target2;
            end
          end
          // [RULE12] Accumulator plus pointer
          OP_IND_JUMP: begin
            next_program_counter = data_pointer + {8'h00, acc};
            next_fetch_addr      = data_pointer + {8'h00, acc};
          end
          // [RULE13] Push low byte first
          OP_LONG_CALL: begin
            // Hold pc so the high push still sees pc plus three
            next_program_counter = program_counter;
            next_stack_pointer = stack_pointer + SP_W'(1);
            ram_we             = 1'b1;
            ram_waddr          = stack_pointer + SP_W'(1);
            ram_wdata          = seq_addr[7:0];
            next_instr_done    = 1'b0;
            next_state         = ST_PUSH_HI;
          end
          // [RULE15] Absolute load
          OP_LONG_JUMP: begin
            next_program_counter = {byte2, byte3};
            next_fetch_addr      = {byte2, byte3};
          end
          default: next_unsupported_op = 1'b1;
        endcase
      end
      ST_PUSH_HI: begin
        // [RULE13] Second push, high byte
        next_stack_pointer   = stack_pointer + SP_W'(1);
        ram_we               = 1'b1;
        ram_waddr            = stack_pointer + SP_W'(1);
        ram_wdata            = seq_addr[15:8];
        // [RULE14] Target from bytes two and three
        next_program_counter = {byte2, byte3};
        next_fetch_addr      = {byte2, byte3};
        next_instr_done      = 1'b1;
        next_state           = ST_REQ;
      end
      default: next_state = ST_REQ;
    endcase
    // Loads win over increments and pushes
    if (pointer_load) begin
      next_data_pointer = pointer_load_value;
    end
    if (sp_load) begin
      next_stack_pointer = sp_load_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state           <= ST_REQ;
      fetch_addr      <= PC_RESET;
      byte_idx        <= 2'h0;
      opcode          <= ZERO_BYTE;
      byte2           <= ZERO_BYTE;
      byte3           <= ZERO_BYTE;
      bit_seen        <= 1'b0;
      code_addr       <= PC_RESET;
      code_rd         <= 1'b0;
      bit_rd          <= 1'b0;
      bit_addr        <= ZERO_BYTE;
      bit_from_latch  <= 1'b0;
      bit_wr          <= 1'b0;
      program_counter <= PC_RESET;
      data_pointer    <= DATA_POINTER_RESET;
      stack_pointer   <= SP_W'(SP_RESET);
      instr_done      <= 1'b0;
      unsupported_op  <= 1'b0;
    end else begin
      state           <= next_state;
      fetch_addr      <= next_fetch_addr;
      byte_idx        <= next_byte_idx;
      opcode          <= next_opcode;
      byte2           <= next_byte2;
      byte3           <= next_byte3;
      bit_seen        <= next_bit_seen;
      code_addr       <= next_code_addr;
      code_rd         <= next_code_rd;
      bit_rd          <= next_bit_rd;
      bit_addr        <= next_bit_addr;
      bit_from_latch  <= next_bit_from_latch;
      bit_wr          <= next_bit_wr;
      program_counter <= next_program_counter;
      data_pointer    <= next_data_pointer;
      stack_pointer   <= next_stack_pointer;
      instr_done      <= next_instr_done;
      unsupported_op  <= next_unsupported_op;
    end
  end

  // Write data is always zero; only the clear form writes
  assign bit_wdata = 1'b0;
  assign pointer_low_byte  = data_pointer[7:0];
  assign pointer_high_byte = data_pointer[15:8];

  AST_PTR_INC: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
    (state == ST_EXEC && opcode == OP_PTR_INC && !pointer_load)
      |=> data_pointer == $past(data_pointer) + ONE_WORD)
    else $error("pointer increment wrong");
  AST_BIT3: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
    (state == ST_EXEC && is_bit_op(opcode) && taken) |=> program_counter == $past(target3))
    else $error("bit branch target wrong");
  AST_SHORT: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE3]
    (state == ST_EXEC && op_len(opcode) == LEN_TWO)
      |=> program_counter == ($past(taken) ? $past(target2) : $past(program_counter) + 16'h0002))
    else $error("short branch target wrong");
  AST_NO_WR: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE4]
    bit_wr |-> $past(opcode) == OP_BIT_SETCL && $past(bit_seen))
    else $error("bit written without cause");
  AST_SETCL: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE5]
    (state == ST_EXEC && opcode == OP_BIT_SETCL && bit_seen) |=> bit_wr && !bit_wdata)
    else $error("set-and-clear did not clear");
  AST_LATCH: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE6]
    bit_rd |-> bit_from_latch == (opcode == OP_BIT_SETCL))
    else $error("wrong bit source");
  AST_IND: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
    (state == ST_EXEC && opcode == OP_IND_JUMP)
      |=> program_counter == $past(data_pointer) + {8'h00, $past(acc)})
    else $error("indirect jump target wrong");
  AST_CALL: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE13]
    (state == ST_EXEC && opcode == OP_LONG_CALL && !sp_load)
      |=> ##1 stack_pointer == $past(stack_pointer, 2) + SP_W'(2)
          && program_counter == {byte2, byte3})
    else $error("long call push or target wrong");
  AST_JUMP: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE15]
    (state == ST_EXEC && opcode == OP_LONG_JUMP) |=> program_counter == {$past(byte2), $past(byte3)})
    else $error("long jump target wrong");
endmodule // bpeu_exec
`default_nettype wire

// file: verilog/bpeu_pkg.sv
// Constants for the branch and pointer execution unit: opcodes, lengths,
// reset values and field widths.
// Assumes the surrounding core supplies accumulator and carry on ref_clk.
`default_nettype none
package bpeu_pkg;
  localparam int unsigned PC_W  = 16;
  localparam int unsigned BYTE_W = 8;

  localparam logic [7:0] OP_PTR_INC   = 8'ha3;
  localparam logic [7:0] OP_BIT_SET   = 8'h20;
  localparam logic [7:0] OP_BIT_SETCL = 8'h10;
  localparam logic [7:0] OP_BIT_CLR   = 8'h30;
  localparam logic [7:0] OP_CARRY     = 8'h40;
  localparam logic [7:0] OP_NO_CARRY  = 8'h50;
  localparam logic [7:0] OP_ACC_ZERO  = 8'h60;
  localparam logic [7:0] OP_ACC_NZERO = 8'h70;
  localparam logic [7:0] OP_IND_JUMP  = 8'h73;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;

  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [7:0]  SP_RESET   = 8'h07;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
  localparam logic [7:0]  ONE_BYTE   = 8'h01;
  localparam logic [15:0] ONE_WORD   = 16'h0001;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  typedef enum logic [2:0] {
    ST_REQ     = 3'b000,
    ST_WAIT    = 3'b001,
    ST_BIT_REQ = 3'b010,
    ST_BIT_WAIT= 3'b011,
    ST_EXEC    = 3'b100,
    ST_PUSH_HI = 3'b101
  } bpeu_state_t;
endpackage
`default_nettype wire

// file: verilog/bpeu_rel_add.sv
// Relative target adder: base plus sign-extended displacement.
// Assumes a 16-bit base; the sum wraps without any flag.
`timescale 1ns/1ps
`default_nettype none
module bpeu_rel_add #(
  parameter int unsigned W = 16
) (
  input  wire logic [W-1:0] base,
  input  wire logic [7:0]   disp,
  output logic      [W-1:0] target
);
  // Wraps modulo two to the W
  assign target = base + {{(W-8){disp[7]}}, disp};
endmodule // bpeu_rel_add
`default_nettype wire

// file: verilog/bpeu_stack_ram.sv
// Internal stack RAM, one write port and one registered read port.
// Assumes a single clock; no reset of the contents.
`timescale 1ns/1ps
`default_nettype none
module bpeu_stack_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // bpeu_stack_ram
`default_nettype wire

// file: sim/bpeu_far_side.sv
// Far-side model: program memory and bit space answering the execution unit.
// Assumes the bench fills mem and bits directly and stalls code answers with hold.
`timescale 1ns/1ps
`default_nettype none
module bpeu_far_side (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic [15:0] code_addr,
  input  wire logic        code_rd,
  output logic      [7:0]  code_data,
  output logic             code_valid,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_rd,
  input  wire logic        bit_from_latch,
  output logic             bit_value,
  output logic             bit_valid,
  input  wire logic        bit_wr,
  input  wire logic        bit_wdata
);
  logic [7:0]  mem [0:65535];
  logic        bits [0:255];
  logic        pend;
  logic        bpend;
  logic        latch_seen;
  logic [15:0] addr;
  logic [7:0]  baddr;
  logic [1:0]  cnt;

  // Data lines toggle outside an answer so a stale value never matches
  always @(posedge ref_clk) begin
    code_valid <= 1'b0;
    bit_valid  <= 1'b0;
    code_data  <= ~code_data;
    bit_value  <= ~bit_value;
    if (bit_wr) begin
      bits[bit_addr] <= bit_wdata;
    end
    if (!rstn) begin
      pend  <= 1'b0;
      bpend <= 1'b0;
    end else begin
      if (code_rd) begin
        pend <= 1'b1;
        addr <= code_addr;
        cnt  <= slow ? 2'h3 : 2'h0;
      end else if (pend && !hold) begin
        if (cnt != 2'h0) begin
          cnt <= cnt - 2'h1;
        end else begin
          pend       <= 1'b0;
          code_valid <= 1'b1;
          code_data  <= mem[addr];
        end
      end
      if (bit_rd) begin
        bpend      <= 1'b1;
        baddr      <= bit_addr;
        latch_seen <= bit_from_latch;
      end else if (bpend) begin
        bpend     <= 1'b0;
        bit_valid <= 1'b1;
        bit_value <= bits[baddr];
      end
    end
  end
endmodule // bpeu_far_side
`default_nettype wire

// file: sim/tb_bpeu_exec.sv
// Self-checking bench for the execution unit, one instruction at a time.
// Assumes the far-side model holds code answers while hold is high.
`timescale 1ns/1ps
`default_nettype none
module tb_bpeu_exec;
  import bpeu_pkg::*;
  logic        ref_clk, rstn, hold, slow, carry_flag, pointer_load, sp_load;
  logic [7:0]  acc, sp_load_value, stack_rd_addr, code_data, bit_addr, stack_rd_data;
  logic [7:0]  pointer_low_byte, pointer_high_byte, stack_pointer;
  logic [15:0] pointer_load_value, code_addr, program_counter, data_pointer;
  logic        code_rd, code_valid, bit_rd, bit_from_latch, bit_value, bit_valid;
  logic        bit_wr, bit_wdata, instr_done, unsupported_op;
  logic [15:0] exp_pc, exp_dp;
  logic [7:0]  exp_sp;
  logic [31:0] r;
  integer      err_count, checked, i;
  integer      seed = 9;
  logic [7:0]  ops [0:10] = '{OP_BIT_SET, OP_BIT_SETCL, OP_BIT_CLR, OP_CARRY, OP_NO_CARRY,
    OP_ACC_ZERO, OP_ACC_NZERO, OP_PTR_INC, OP_IND_JUMP, OP_LONG_CALL, OP_LONG_JUMP};

  bpeu_exec bpeu_exec_inst (.ref_clk(ref_clk), .rstn(rstn), .code_addr(code_addr),
    .code_rd(code_rd), .code_data(code_data), .code_valid(code_valid), .acc(acc),
    .carry_flag(carry_flag), .bit_addr(bit_addr), .bit_rd(bit_rd),
    .bit_from_latch(bit_from_latch), .bit_value(bit_value), .bit_valid(bit_valid),
    .bit_wr(bit_wr), .bit_wdata(bit_wdata), .pointer_load(pointer_load),
    .pointer_load_value(pointer_load_value), .sp_load(sp_load),
    .sp_load_value(sp_load_value), .stack_rd_addr(stack_rd_addr),
    .stack_rd_data(stack_rd_data), .program_counter(program_counter),
    .data_pointer(data_pointer), .pointer_low_byte(pointer_low_byte),
    .pointer_high_byte(pointer_high_byte), .stack_pointer(stack_pointer),
    .instr_done(instr_done), .unsupported_op(unsupported_op));

  bpeu_far_side bpeu_far_side_inst (.ref_clk(ref_clk), .rstn(rstn), .hold(hold),
    .slow(slow), .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data),
    .code_valid(code_valid), .bit_addr(bit_addr), .bit_rd(bit_rd),
    .bit_from_latch(bit_from_latch), .bit_value(bit_value), .bit_valid(bit_valid),
    .bit_wr(bit_wr), .bit_wdata(bit_wdata));

  task automatic fail(input string what);
    err_count++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] want, input string what);
    checked++;
    if (got !== want) fail($sformatf("%s got %h want %h", what, got, want));
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want, input string what);
    checked++;
    if (got !== want) fail($sformatf("%s got %h want %h", what, got, want));
  endtask

  task automatic chk_bit(input logic got, input logic want, input string what);
    checked++;
    if (got !== want) fail($sformatf("%s got %b want %b", what, got, want));
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] rel(input logic [15:0] base, input logic [7:0] d, input logic go);
    return go ? base + {{8{d[7]}}, d} : base;
  endfunction

  function automatic logic in_group(input logic [7:0] op);
    in_group = 1'b0;
    for (int k = 0; k < 11; k++) begin
      if (ops[k] == op) in_group = 1'b1;
    end
  endfunction

  function automatic logic [15:0] want_pc(input logic [7:0] op, b1, b2, a,
                                          input logic c, bv);
    case (op)
      OP_PTR_INC:   return exp_pc + 16'h1;
      OP_BIT_SET:   return rel(exp_pc + 16'h3, b2, bv);
      OP_BIT_SETCL: return rel(exp_pc + 16'h3, b2, bv);
      OP_BIT_CLR:   return rel(exp_pc + 16'h3, b2, !bv);
      OP_CARRY:     return rel(exp_pc + 16'h2, b1, c);
      OP_NO_CARRY:  return rel(exp_pc + 16'h2, b1, !c);
      OP_ACC_ZERO:  return rel(exp_pc + 16'h2, b1, a == 8'h00);
      OP_ACC_NZERO: return rel(exp_pc + 16'h2, b1, a != 8'h00);
      OP_IND_JUMP:  return exp_dp + {8'h00, a};
      OP_LONG_CALL, OP_LONG_JUMP: return {b1, b2};
      default:      return exp_pc + 16'h1;
    endcase
  endfunction

  task automatic set_regs(input logic [15:0] dp, input logic [7:0] sp);
    pointer_load       = 1'b1;
    pointer_load_value = dp;
    sp_load            = 1'b1;
    sp_load_value      = sp;
    @(negedge ref_clk);
    pointer_load = 1'b0;
    sp_load      = 1'b0;
    exp_dp       = dp;
    exp_sp       = sp;
  endtask

  // Places one instruction at the expected pc, lets it run, checks the outcome
  task automatic run_op(input logic [7:0] op, b1, b2, a, input logic c, bv, sl);
    logic [15:0] ret;
    int          n;
    bpeu_far_side_inst.mem[exp_pc] = op;
    bpeu_far_side_inst.mem[exp_pc + 16'h1] = b1;
    bpeu_far_side_inst.mem[exp_pc + 16'h2] = b2;
    bpeu_far_side_inst.bits[b1] = bv;
    acc        = a;
    carry_flag = c;
    slow       = sl;
    ret        = exp_pc + 16'h3;
    @(negedge ref_clk);
    hold       = 1'b0;
    n          = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_done !== 1'b1 && n < 200);
    hold = 1'b1;
    chk_bit(instr_done, 1'b1, "instruction done");
    chk_bit(unsupported_op, !in_group(op), "unsupported flag"); // flag raised only for unknown opcode
    exp_pc = want_pc(op, b1, b2, a, c, bv);
    if (op == OP_PTR_INC) exp_dp = exp_dp + 16'h1;
    chk_word(program_counter, exp_pc, "program counter");
    chk_word(data_pointer, exp_dp, "data pointer");
    chk_byte(pointer_high_byte, exp_dp[15:8], "pointer high");
    chk_byte(pointer_low_byte, exp_dp[7:0], "pointer low");
    if (op == OP_LONG_CALL) begin
      stack_rd_addr = exp_sp + 8'h1;
      @(negedge ref_clk);
      chk_byte(stack_rd_data, ret[7:0], "pushed low");
      stack_rd_addr = exp_sp + 8'h2;
      @(negedge ref_clk);
      chk_byte(stack_rd_data, ret[15:8], "pushed high");
      exp_sp = exp_sp + 8'h2;
    end
    chk_byte(stack_pointer, exp_sp, "stack pointer");
    if (op == OP_BIT_SET || op == OP_BIT_SETCL || op == OP_BIT_CLR) begin
      @(negedge ref_clk);
      chk_bit(bpeu_far_side_inst.bits[b1], bv && op != OP_BIT_SETCL, "bit");
      chk_bit(bpeu_far_side_inst.latch_seen, op == OP_BIT_SETCL, "latch");
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    {rstn, slow, carry_flag, pointer_load, sp_load} = 5'h00;
    {acc, sp_load_value, stack_rd_addr, pointer_load_value} = 40'h0;
    hold      = 1'b1;
    err_count = 0;
    checked   = 0;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    chk_word(program_counter, 16'h0000, "pc after reset");
    chk_word(data_pointer, 16'h0000, "pointer after reset");
    chk_byte(stack_pointer, 8'h07, "sp after reset");
    exp_pc = 16'h0000;
    set_regs(16'h12fe, 8'h07);
    repeat (3) run_op(OP_PTR_INC, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    set_regs(16'hffff, 8'h07);
    run_op(OP_PTR_INC, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
    run_op(OP_LONG_JUMP, 8'h01, 8'h23, 8'h00, 1'b0, 1'b0, 1'b0);
    run_op(OP_LONG_CALL, 8'h12, 8'h34, 8'h00, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 14; i++) begin
      run_op(ops[i / 2], 8'h40 + i[7:0], i[1] ? 8'hf0 : 8'h10, i[0] ? 8'h80 : 8'h00,
             i[0], i[0], i[2]);
    end
    run_op(OP_LONG_JUMP, 8'hff, 8'hf0, 8'h00, 1'b0, 1'b0, 1'b0);
    run_op(OP_CARRY, 8'h7f, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
    run_op(OP_ACC_ZERO, 8'h80, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    set_regs(16'hff01, 8'hfe);
    run_op(OP_IND_JUMP, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0, 1'b0);
    run_op(OP_LONG_CALL, 8'hab, 8'hcd, 8'h00, 1'b0, 1'b0, 1'b0);
    run_op(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0); // skip of unknown opcode
    for (i = 0; i < 80; i++) begin
      r = $random(seed);
      run_op(ops[r[31:4] % 11], r[15:8], r[23:16], r[1] ? 8'h00 : r[31:24],
             r[2], r[3], r[0]);
    end
    give_verdict();
  end
endmodule // tb_bpeu_exec
`default_nettype wire
